// ---- ssrw_pkg.sv ----
// Constants and carriers for the supply supervisor, reset and watchdog block.
// Assumes a single free-running core clock at 40 MHz.
package ssrw_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned RESET_HOLD_MS   = 200;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned RESET_HOLD_CYC  =
    (CLK_HZ / 1000) * RESET_HOLD_MS;
  localparam int unsigned WDOG_TIMEOUT_CYC =
    (CLK_HZ / 1000) * WDOG_TIMEOUT_MS;
  localparam int unsigned CNT_W = 32;

  // Synchronised comparator flags
  typedef struct packed {
    logic below_reset;
    logic below_supply_warning_n;
    logic below_backup;
  } ssrw_flags_s;

  localparam ssrw_flags_s FLAGS_RST = 3'h0;

  // Synchronised pin levels from the processor side
  typedef struct packed {
    logic kick;
    logic kick_float;
    logic cs_n;
  } ssrw_pins_s;

  // Pin stages reset high so chip select starts deasserted
  localparam ssrw_pins_s PINS_RST = 3'h7;

endpackage

// ---- ssrw_top.sv ----
// Supply supervisor: reset generation with hold timer, watchdog,
// low-line warning, chip-enable gating and backup supply selection.
// Assumes comparator flags and pins are asynchronous to core_clk.
//
// Behaviour
// R1: Reset held while supply low, then at least the hold time afterwards.
// R2: Supply dipping low again restarts the reset hold count from zero.
// R3: Kick input steady longer than watchdog timeout causes a timed reset.
// R4: Floating kick input disables watchdog resets; other party leaves it open.
// R5: Active-high reset is always the exact inverse of active-low reset.
// R6: Chip-select output held high whenever the chip-enable gate is off.
// R7: Backup supply chosen only when supply below reset and backup levels.
// R8: Backup above main supply alone causes neither reset nor switchover.
// R9: Low-line warning low while low-line comparator flag reports low.
// R10: Watchdog counter cleared on reset or kick toggle, counts after release.
// R11: Chip-enable path disabled while reset is asserted.
// R12: Timeouts are counters of the internal clock derived from its rate.
// R13: Comparator flags pass synchronising stages before use.
`timescale 1ns/1ps
module ssrw_top #(
  parameter int unsigned RESET_HOLD_CYC   = ssrw_pkg::RESET_HOLD_CYC,
  parameter int unsigned WDOG_TIMEOUT_CYC = ssrw_pkg::WDOG_TIMEOUT_CYC
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic below_reset_in,
  input  wire logic below_supply_warning_n_in,
  input  wire logic below_backup_in,
  input  wire logic watchdog_kick_in,
  input  wire logic kick_float_in,
  input  wire logic chip_sel_n_in,
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      supply_warning_n,
  output logic      chip_sel_n_out,
  output logic      backup_select
);

  localparam int W = ssrw_pkg::CNT_W;

  // Three-stage synchronisers; change accepted when stages two and three agree
  logic [2:0] s1_r, s2_r, s3_r;
  logic [2:0] kin_r, kmid_r, kout_r;   // kick, float, chip select
  logic [2:0] raw;
  logic [2:0] kraw;
  ssrw_pkg::ssrw_flags_s flags_r;
  ssrw_pkg::ssrw_pins_s pins_r;

  assign raw  = {below_reset_in, below_supply_warning_n_in, below_backup_in};
  assign kraw = {watchdog_kick_in, kick_float_in, chip_sel_n_in};

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_r   <= 3'h0;
      s2_r   <= 3'h0;
      s3_r   <= 3'h0;
      kin_r  <= ssrw_pkg::PINS_RST;
      kmid_r <= ssrw_pkg::PINS_RST;
      kout_r <= ssrw_pkg::PINS_RST;
    end else begin
      s1_r   <= raw;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      kin_r  <= kraw;
      kmid_r <= kin_r;
      kout_r <= kmid_r;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flags_r <= ssrw_pkg::FLAGS_RST;
      pins_r  <= ssrw_pkg::PINS_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (s2_r[i] == s3_r[i])
          flags_r[i] <= s3_r[i]; // R13
        if (kmid_r[i] == kout_r[i])
          pins_r[i] <= kout_r[i];
      end
    end
  end

  flag_sync_a: assert property ( // R13
    @(posedge core_clk) disable iff (reset)
    (s2_r == s3_r) |=> flags_r == $past(s3_r))
    else $error("agreed comparator level not taken");

  logic kick, kick_float, cs_n;
  assign kick       = pins_r.kick;
  assign kick_float = pins_r.kick_float;
  assign cs_n       = pins_r.cs_n;

  // Reset hold timer
  logic [W-1:0] hold_cnt_r;
  logic [W-1:0] wd_cnt_r;
  logic         kick_prev_r;
  logic         wd_fire;
  logic         rst_act_r;

  assign wd_fire = !rst_act_r && !kick_float &&
                   (wd_cnt_r >= W'(WDOG_TIMEOUT_CYC - 1)); // R3 R4

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rst_act_r  <= 1'b1;
      hold_cnt_r <= '0;
    end else if (flags_r.below_reset || wd_fire) begin
      rst_act_r  <= 1'b1; // R1 R3 R8
      hold_cnt_r <= '0; // R2
    end else if (rst_act_r) begin
      if (hold_cnt_r >= W'(RESET_HOLD_CYC - 1)) begin
        rst_act_r  <= 1'b0; // R12
        hold_cnt_r <= '0;
      end else begin
        hold_cnt_r <= hold_cnt_r + W'(1); // R1
      end
    end
  end

  rst_min_hold_a: assert property ( // R1
    @(posedge core_clk) disable iff (reset)
    (rst_act_r && hold_cnt_r < W'(RESET_HOLD_CYC - 1)) |=> rst_act_r)
    else $error("reset released before hold time");

  hold_end_a: assert property ( // R12
    @(posedge core_clk) disable iff (reset)
    (rst_act_r && !flags_r.below_reset &&
     hold_cnt_r == W'(RESET_HOLD_CYC - 1)) |=> !rst_act_r)
    else $error("reset not released at hold count");

  wd_fire_rst_a: assert property ( // R3
    @(posedge core_clk) disable iff (reset)
    wd_fire |-> ##2 !reset_out_n)
    else $error("watchdog timeout did not reset");

  // Watchdog counter
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      kick_prev_r <= 1'b1;
      wd_cnt_r    <= '0;
    end else begin
      kick_prev_r <= kick;
      if (rst_act_r || wd_fire || kick != kick_prev_r || kick_float)
        wd_cnt_r <= '0; // R10 R4
      else
        wd_cnt_r <= wd_cnt_r + W'(1); // R12
    end
  end

  wd_count_a: assert property ( // R10
    @(posedge core_clk) disable iff (reset)
    (!rst_act_r && !wd_fire && !kick_float && kick == kick_prev_r)
    |=> wd_cnt_r == $past(wd_cnt_r) + W'(1))
    else $error("watchdog count did not advance");

  wd_float_rst_a: assert property ( // R4
    @(posedge core_clk) disable iff (reset)
    (kick_float && !rst_act_r && !flags_r.below_reset) |=> !rst_act_r)
    else $error("reset raised while kick input floats");

  // Outputs
  logic gate_open;
  assign gate_open = !rst_act_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reset_out_n      <= 1'b0;
      reset_out        <= 1'b1;
      supply_warning_n <= 1'b0;
      chip_sel_n_out   <= 1'b1;
      backup_select    <= 1'b0;
    end else begin
      reset_out_n      <= !rst_act_r;
      reset_out        <= rst_act_r; // R5
      supply_warning_n <= !flags_r.below_supply_warning_n; // R9
      chip_sel_n_out   <= gate_open ? cs_n : 1'b1; // R6 R11
      backup_select    <= flags_r.below_reset &&
                          flags_r.below_backup; // R7 R8
    end
  end

  cs_pass_a: assert property ( // R6
    @(posedge core_clk) disable iff (reset)
    gate_open |=> chip_sel_n_out == $past(cs_n))
    else $error("chip select not passed while gate open");

  backup_on_a: assert property ( // R7
    @(posedge core_clk) disable iff (reset)
    (flags_r.below_reset && flags_r.below_backup) |=> backup_select)
    else $error("backup supply not selected");

  // Checks
  rst_inverse_a: assert property ( // R5
    @(posedge core_clk) disable iff (reset) reset_out == !reset_out_n)
    else $error("reset outputs not complementary");

  rst_low_a: assert property ( // R1
    @(posedge core_clk) disable iff (reset)
    flags_r.below_reset |-> ##2 !reset_out_n)
    else $error("reset not asserted for low supply");

  rst_hold_a: assert property ( // R2
    @(posedge core_clk) disable iff (reset)
    (rst_act_r && hold_cnt_r != '0) ##1 flags_r.below_reset
    |=> hold_cnt_r == '0)
    else $error("hold count not restarted");

  cs_gate_a: assert property ( // R11
    @(posedge core_clk) disable iff (reset)
    rst_act_r |=> chip_sel_n_out)
    else $error("chip select passed during reset");

  backup_sel_a: assert property ( // R7
    @(posedge core_clk) disable iff (reset)
    (flags_r.below_backup && !flags_r.below_reset) |=> !backup_select)
    else $error("switchover without low supply");

  warn_out_a: assert property ( // R9
    @(posedge core_clk) disable iff (reset)
    flags_r.below_supply_warning_n |=> !supply_warning_n)
    else $error("warning not driven low");

  wd_clear_a: assert property ( // R10
    @(posedge core_clk) disable iff (reset)
    rst_act_r |=> wd_cnt_r == '0)
    else $error("watchdog counted during reset");

  wd_float_a: assert property ( // R4
    @(posedge core_clk) disable iff (reset)
    kick_float |-> !wd_fire)
    else $error("watchdog fired while disabled");

endmodule

// ---- ssrw_cpu_model.sv ----
// Processor side model: kicks the watchdog and can leave the kick pin open.
// Assumes the bench drives the enables off the falling clock edge.
`timescale 1ns/1ps
module ssrw_cpu_model (
  input  wire logic core_clk,
  input  wire logic kick_en,
  input  wire logic float_en,
  output logic      watchdog_kick_in,
  output logic      kick_float_in
);
  logic [2:0] div_r;
  initial begin
    div_r = 3'h0;
    watchdog_kick_in = 1'b0;
  end
  // Open pin is reported as floating and then holds still
  assign kick_float_in = float_en;
  always @(negedge core_clk) begin
    div_r <= div_r + 3'h1;
    if (kick_en && !float_en && div_r == 3'h7) begin
      watchdog_kick_in <= !watchdog_kick_in;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the supervisor with short hold and watchdog counts.
// Assumes ssrw_pkg, ssrw_top and ssrw_cpu_model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic core_clk, reset, b_rst, b_ll, b_bk, cs_n, kick_en, flt_en;
  logic rst_n_o, rst_o, warn_n, cs_o, bsel, kick, kflt;
  logic [4:0] exp_q[$];
  int bad_count, num_checks, seed;
  event chk_ev;
  ssrw_cpu_model u_cpu (.core_clk(core_clk), .kick_en(kick_en),
    .float_en(flt_en), .watchdog_kick_in(kick), .kick_float_in(kflt));
  ssrw_top #(.RESET_HOLD_CYC(20), .WDOG_TIMEOUT_CYC(50)) u_dut (
    .core_clk(core_clk), .reset(reset), .below_reset_in(b_rst),
    .below_supply_warning_n_in(b_ll), .below_backup_in(b_bk),
    .watchdog_kick_in(kick), .kick_float_in(kflt), .chip_sel_n_in(cs_n),
    .reset_out_n(rst_n_o), .reset_out(rst_o), .supply_warning_n(warn_n),
    .chip_sel_n_out(cs_o), .backup_select(bsel));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Expected outputs follow from the reset level and the inputs
  task automatic expect_now(input logic rn, input logic w, input logic b);
    exp_q.push_back({rn, !rn, rn ? cs_n : 1'b1, w, b});
    ->chk_ev;
  endtask
  task automatic compare_out(input logic [4:0] e);
    num_checks++;
    if ({rst_n_o, rst_o, cs_o, warn_n, bsel} !== e) begin
      bad_count++;
      $display("ERROR %0t outputs %b expected %b", $time,
        {rst_n_o, rst_o, cs_o, warn_n, bsel}, e);
    end
  endtask
  task automatic wait_rst(input logic v);
    int i;
    for (i = 0; i < 200 && rst_n_o !== v; i++) cyc(1);
    if (i == 200) begin
      bad_count++;
      $display("ERROR %0t reset level wait timed out", $time);
      report_and_stop();
    end
  endtask
  initial forever begin
    @chk_ev;
    #1;
    compare_out(exp_q.pop_front());
  end
  initial begin
    seed = 52;
    bad_count = 0;
    num_checks = 0;
    {b_rst, b_ll, b_bk, flt_en} = 4'h0;
    kick_en = 1'b1;
    cs_n = 1'b0;
    reset = 1'b1;
    cyc(10);
    reset = 1'b0;
    cyc(10);
    expect_now(1'b0, 1'b1, 1'b0);
    cyc(20);
    expect_now(1'b1, 1'b1, 1'b0);
    $display("power-up test done");
    b_rst = 1'b1; cyc(6); b_rst = 1'b0; cyc(14);
    b_rst = 1'b1; cyc(6); b_rst = 1'b0; cyc(16);
    expect_now(1'b0, 1'b1, 1'b0);
    cs_n = 1'($random(seed));
    wait_rst(1'b1);
    cyc(2);
    expect_now(1'b1, 1'b1, 1'b0);
    $display("restart test done");
    b_ll = 1'b1; cyc(6); expect_now(1'b1, 1'b0, 1'b0);
    b_ll = 1'b0; b_bk = 1'b1; cyc(6); expect_now(1'b1, 1'b1, 1'b0);
    b_rst = 1'b1; cyc(6); expect_now(1'b0, 1'b1, 1'b1);
    b_rst = 1'b0; b_bk = 1'b0;
    wait_rst(1'b1);
    $display("supply test done");
    cyc(120); expect_now(1'b1, 1'b1, 1'b0);
    kick_en = 1'b0; cyc(36); expect_now(1'b1, 1'b1, 1'b0);
    wait_rst(1'b0); cyc(1); expect_now(1'b0, 1'b1, 1'b0);
    kick_en = 1'b1;
    wait_rst(1'b1);
    $display("watchdog test done");
    cs_n = 1'($random(seed));
    kick_en = 1'b0; flt_en = 1'b1;
    cyc(150); expect_now(1'b1, 1'b1, 1'b0);
    $display("floating kick test done");
    cyc(2);
    report_and_stop();
  end
endmodule
